//--- core/acd_pkg.sv
package acd_pkg;

  // ---------------------------------------------------------------
  // Register map: printed offsets are register indices, byte = 4x
  // ---------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [7:0] TRIG_IDX = 8'h49;
  localparam logic [7:0] FILT_IDX = 8'h50;
  localparam logic [7:0] CTRL_IDX = 8'h51;
  localparam logic [7:0] STAT_IDX = 8'h52;
  localparam logic [ADDR_W-1:0] TRIG_ADDR = {2'h0, TRIG_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] FILT_ADDR = {2'h0, FILT_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] CTRL_ADDR = {2'h0, CTRL_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] STAT_ADDR = {2'h0, STAT_IDX, 2'h0};
  localparam logic [7:0] REG_RESET = 8'h00;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int TRIG_HALVE_BYP_BIT = 7;
  localparam int TRIG_SINC16_BIT = 6;
  localparam int TRIG_LOW_LATENCY_IIR_ENABLE_BIT = 5;
  localparam int FILT_DROOP_BYP_BIT = 7;
  localparam int FILT_FLAT_BYP_BIT = 6;
  localparam int FILT_LPF_HI = 5;
  localparam int FILT_LPF_LO = 4;
  localparam int CTRL_MODE_HI = 3;
  localparam int CTRL_NEGATIVE_BIAS_ROUNDING_BIT = 4;
  localparam int STAT_SAMPLE_LO = 16;

  // ---------------------------------------------------------------
  // Operating modes and bus answers
  // ---------------------------------------------------------------
  localparam logic [3:0] MODE_HP = 4'hc;
  localparam logic [3:0] MODE_RBW = 4'h8;
  localparam logic [3:0] MODE_LP = 4'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // Rates and arithmetic
  // ---------------------------------------------------------------
  localparam int MOD_RATE_KHZ = 1024;
  localparam int IIR1_CUTOFF_KHZ = 5;
  localparam logic [4:0] SINC32_LAST = 5'h1f;
  localparam logic [4:0] SINC16_LAST = 5'h0f;
  localparam int SINC16_GAIN_SHIFT = 3;
  localparam int FRAC_BITS = 4;
  localparam int IIR1_SHIFT = 1;
  localparam int DROOP_CENTER_SHIFT = 2;
  localparam int DROOP_SIDE_SHIFT = 3;

  typedef enum logic [1:0] {WS_COLLECT = 2'b01, WS_RESP = 2'b10} acd_wstate_t;
  typedef enum logic [1:0] {RS_IDLE = 2'b01, RS_DATA = 2'b10} acd_rstate_t;

endpackage

//--- core/acd_sinc3.sv
`timescale 1ns/1ps
module acd_sinc3 import acd_pkg::*; #(
  parameter int W = 24
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Control
  input wire logic run,
  input wire logic ratio16,
  // Modulator bit stream
  input wire logic inValid,
  input wire logic inBit,
  // Decimated output
  output logic outValid,
  output logic signed [W-1:0] outData
);

  logic signed [W-1:0] integ [0:2];
  logic signed [W-1:0] combDly [0:2];
  logic signed [W-1:0] combIn [0:3];
  logic signed [W-1:0] stim;
  logic [4:0] phase;
  logic [4:0] lastPhase;
  logic dump;

  // Bit maps to +1 or -1; wrapping arithmetic is exact for a CIC
  assign stim = inBit ? {{(W-1){1'b0}}, 1'b1} : {W{1'b1}};
  assign lastPhase = ratio16 ? SINC16_LAST : SINC32_LAST;
  // Gated by run so that leaving a run mode cannot emit one last sample
  assign dump = run && inValid && (phase == lastPhase);
  assign combIn[0] = integ[2];

  // Decimation phase; a ratio change mid-count just wraps once
  always_ff @(posedge clk) begin
    if (!rstn || !run) begin
      phase <= '0;
    end else if (inValid) begin
      phase <= dump ? 5'h00 : phase + 5'h01;
    end
  end

  // Integrator and comb stages
  for (genvar g = 0; g < 3; g++) begin : g_stage
    logic signed [W-1:0] feed;
    if (g == 0) begin : g_first
      assign feed = stim;
    end else begin : g_next
      assign feed = integ[g-1];
    end
    always_ff @(posedge clk) begin
      if (!rstn || !run) begin
        integ[g] <= '0;
        combDly[g] <= '0;
      end else begin
        if (inValid) begin
          integ[g] <= integ[g] + feed;
        end
        if (dump) begin
          combDly[g] <= combIn[g];
        end
      end
    end
    assign combIn[g+1] = combIn[g] - combDly[g];
  end

  // Registered decimated sample
  always_ff @(posedge clk) begin
    if (!rstn) begin
      outValid <= 1'b0;
      outData <= '0;
    end else begin
      outValid <= dump;
      if (dump) begin
        outData <= combIn[3];
      end
    end
  end

endmodule

//--- core/acd_filter_chain.sv
`timescale 1ns/1ps
// Functional notes
// - Low-latency first-order IIR, 5 kHz cutoff, off after reset.
// - Low-latency IIR works only in high performance, reduced bandwidth, low power.
// - Writing one to the IIR enable bit turns the low-latency IIR on.
// - Stage order: sinc decimator, droop compensator, then halving filter.
// - Rounding to 16 bits selectable; negative_bias_rounding adds one to negatives only.
// - Decimation stages run only in the three sigma-delta modes.
// - From 1024 kHz: 32x with halving 16 kHz, bypassed 32, 16x 64.
// - Trigger bit 6 selects sinc ratio: zero 32x at reset, one 16x.
// - Sinc ratio 16x forces the halving stage into bypass.
// - Filter bit 7 bypasses the droop compensator; zero keeps it active.
// - Halving stage decimates by two; trigger bit 7 bypasses it.
// - Filter bits 5:4 hold low-pass cutoff select, zero means off. Stored only; the chain has no low-pass stage.
// - Filter bit 6 bypasses the flattener; resets to zero. Stored only; the chain has no flattener.
module acd_filter_chain import acd_pkg::*; #(
  parameter int W = 24
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // AXI4-Lite write address and data
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Modulator bit stream at the 1024 kHz sample rate
  input wire logic modValid,
  input wire logic modBit,
  // Output sample stream
  output logic sampleValid,
  output logic signed [15:0] sampleOut
);

  // ---------------------------------------------------------------
  // Register bus slave
  // ---------------------------------------------------------------
  acd_wstate_t wstate;
  acd_rstate_t rstate;
  logic awGot, wGot, wrLane0, regWrite;
  logic [ADDR_W-1:0] wrAddr;
  logic [7:0] wrByte, trigCfg, filtCfg, ctrlCfg;
  logic [31:0] statusWord;

  assign regWrite = (wstate == WS_COLLECT) && awGot && wGot;

  // Address and data are each taken once, in either order
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      awGot <= 1'b0;
      wGot <= 1'b0;
      wrAddr <= '0;
      wrByte <= 8'h00;
      wrLane0 <= 1'b0;
    end else begin
      s_axi_awready <= (wstate == WS_COLLECT) && !awGot && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= (wstate == WS_COLLECT) && !wGot && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        awGot <= 1'b1;
        wrAddr <= s_axi_awaddr;
      end else if (s_axi_bvalid && s_axi_bready) begin
        awGot <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wGot <= 1'b1;
        wrByte <= s_axi_wdata[7:0];
        wrLane0 <= s_axi_wstrb[0];
      end else if (s_axi_bvalid && s_axi_bready) begin
        wGot <= 1'b0;
      end
    end
  end

  // Write response once both halves are in
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wstate <= WS_COLLECT;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      case (wstate)
        WS_COLLECT: begin
          if (awGot && wGot) begin
            wstate <= WS_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wrAddr == TRIG_ADDR || wrAddr == FILT_ADDR ||
                            wrAddr == CTRL_ADDR) ? RESP_OKAY : RESP_SLVERR;
          end
        end
        WS_RESP: begin
          if (s_axi_bready) begin
            wstate <= WS_COLLECT;
            s_axi_bvalid <= 1'b0;
          end
        end
        default: begin
          wstate <= WS_COLLECT;
          s_axi_bvalid <= 1'b0;
        end
      endcase
    end
  end

  // Configuration registers; all fields reset to zero
  always_ff @(posedge clk) begin
    if (!rstn) begin
      trigCfg <= REG_RESET;
      filtCfg <= REG_RESET;
      ctrlCfg <= REG_RESET;
    end else if (regWrite && wrLane0) begin
      if (wrAddr == TRIG_ADDR) begin
        trigCfg <= wrByte;
      end
      if (wrAddr == FILT_ADDR) begin
        filtCfg <= wrByte;
      end
      if (wrAddr == CTRL_ADDR) begin
        ctrlCfg <= wrByte;
      end
    end
  end

  // Read channel; unmapped reads return zero with an error answer
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rstate <= RS_IDLE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= (rstate == RS_IDLE) && !(s_axi_arvalid && s_axi_arready);
      case (rstate)
        RS_IDLE: begin
          if (s_axi_arvalid && s_axi_arready) begin
            rstate <= RS_DATA;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            case (s_axi_araddr)
              TRIG_ADDR: s_axi_rdata <= {24'h000000, trigCfg};
              FILT_ADDR: s_axi_rdata <= {24'h000000, filtCfg};
              CTRL_ADDR: s_axi_rdata <= {24'h000000, ctrlCfg};
              STAT_ADDR: s_axi_rdata <= statusWord;
              default: begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= RESP_SLVERR;
              end
            endcase
          end
        end
        RS_DATA: begin
          if (s_axi_rready) begin
            rstate <= RS_IDLE;
            s_axi_rvalid <= 1'b0;
          end
        end
        default: begin
          rstate <= RS_IDLE;
          s_axi_rvalid <= 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Mode gating and stage selection
  // ---------------------------------------------------------------
  logic [3:0] opMode;
  logic chainOn, sinc16, halveActive, droopBypass, iir1Active, floorRound;

  assign opMode = ctrlCfg[CTRL_MODE_HI:0];
  // SAR-based modes and standby leave the whole chain idle
  assign chainOn = (opMode == MODE_HP) || (opMode == MODE_RBW) || (opMode == MODE_LP);
  assign sinc16 = trigCfg[TRIG_SINC16_BIT];
  // 16x overrides the halving stage's own bypass bit
  assign halveActive = !trigCfg[TRIG_HALVE_BYP_BIT] && !sinc16;
  assign droopBypass = filtCfg[FILT_DROOP_BYP_BIT];
  assign iir1Active = trigCfg[TRIG_LOW_LATENCY_IIR_ENABLE_BIT] && chainOn;
  assign floorRound = ctrlCfg[CTRL_NEGATIVE_BIAS_ROUNDING_BIT];

  // ---------------------------------------------------------------
  // Sinc decimator, then droop compensator, then halving filter
  // ---------------------------------------------------------------
  logic sincValid, dcfValid, halfPhase, halfValid;
  logic signed [W-1:0] sincData, stage0, tapA, tapB, droopSum, dcfData, halfHold, halfData;

  acd_sinc3 #(
    .W(W)
  ) u_sinc (
    .clk(clk),
    .rstn(rstn),
    .run(chainOn),
    .ratio16(sinc16),
    .inValid(modValid),
    .inBit(modBit),
    .outValid(sincValid),
    .outData(sincData)
  );

  // 16x has one eighth of the 32x gain; shift to keep one scale
  assign stage0 = (sinc16 ? (sincData <<< SINC16_GAIN_SHIFT) : sincData) <<< FRAC_BITS;
  // Taps -1/8, 10/8, -1/8: unity DC gain, lifts the sinc droop
  assign droopSum = tapA + (tapA >>> DROOP_CENTER_SHIFT) - ((stage0 + tapB) >>> DROOP_SIDE_SHIFT);

  // Droop compensator works on every sinc output sample
  always_ff @(posedge clk) begin
    if (!rstn || !chainOn) begin
      tapA <= '0;
      tapB <= '0;
      dcfValid <= 1'b0;
      dcfData <= '0;
    end else begin
      dcfValid <= sincValid;
      if (sincValid) begin
        tapA <= stage0;
        tapB <= tapA;
        dcfData <= droopBypass ? stage0 : droopSum;
      end
    end
  end

  // Halving stage; a pair average stands in for the higher order response
  always_ff @(posedge clk) begin
    if (!rstn || !chainOn) begin
      halfPhase <= 1'b0;
      halfHold <= '0;
      halfValid <= 1'b0;
      halfData <= '0;
    end else begin
      halfValid <= 1'b0;
      if (dcfValid) begin
        if (halveActive) begin
          halfPhase <= !halfPhase;
          halfHold <= dcfData;
          if (halfPhase) begin
            halfValid <= 1'b1;
            halfData <= (halfHold >>> 1) + (dcfData >>> 1);
          end
        end else begin
          halfPhase <= 1'b0;
          halfValid <= 1'b1;
          halfData <= dcfData;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Low-latency first-order IIR and output rounding
  // ---------------------------------------------------------------
  logic iirValid, satHi, satLo;
  logic signed [W-1:0] iirState, iirData, iirNext, truncVal, roundVal;

  // Fixed coefficient; the corner sits near IIR1_CUTOFF_KHZ at the base rate
  assign iirNext = iirState + ((halfData - iirState) >>> IIR1_SHIFT);

  // Disabled filter tracks its input so enabling starts without a step
  always_ff @(posedge clk) begin
    if (!rstn || !chainOn) begin
      iirState <= '0;
      iirValid <= 1'b0;
      iirData <= '0;
    end else begin
      iirValid <= halfValid;
      if (halfValid) begin
        iirState <= iir1Active ? iirNext : halfData;
        iirData <= iir1Active ? iirNext : halfData;
      end
    end
  end

  assign truncVal = iirData >>> FRAC_BITS;
  // Negative_bias_rounding method lifts negatives by one to cut the truncation offset
  assign roundVal = (floorRound && iirData[W-1]) ? truncVal + W'(1) : truncVal;
  assign satHi = !roundVal[W-1] && (roundVal[W-2:15] != '0);
  assign satLo = roundVal[W-1] && (roundVal[W-2:15] != '1);

  // One-cycle strobe with each saturated 16-bit sample
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sampleValid <= 1'b0;
      sampleOut <= 16'h0000;
    end else begin
      sampleValid <= iirValid;
      if (iirValid) begin
        sampleOut <= satHi ? 16'h7fff : (satLo ? 16'h8000 : roundVal[15:0]);
      end
    end
  end

  assign statusWord = {sampleOut, 12'h000, iir1Active, halveActive, sinc16, chainOn};

  // ---------------------------------------------------------------
  // Assertions and covers
  // ---------------------------------------------------------------
  a_iir1_reset_off: assert property (@(posedge clk) disable iff (!rstn)
    $past(!rstn) |-> !iir1Active && !trigCfg[TRIG_LOW_LATENCY_IIR_ENABLE_BIT])
    else $error("low-latency filter on after reset");
  a_iir1_mode_gate: assert property (@(posedge clk) disable iff (!rstn)
    !chainOn ##1 !chainOn |-> !iir1Active && !iirValid && iirState == '0)
    else $error("low-latency filter active outside sigma-delta modes");
  a_iir1_enable_write: assert property (@(posedge clk) disable iff (!rstn)
    regWrite && wrLane0 && wrAddr == TRIG_ADDR && wrByte[TRIG_LOW_LATENCY_IIR_ENABLE_BIT] && chainOn
    |=> iir1Active ##1 (iir1Active || regWrite || !chainOn))
    else $error("enable write did not turn the filter on");
  a_stage_order: assert property (@(posedge clk) disable iff (!rstn)
    sincValid && chainOn ##1 chainOn |-> dcfValid ##1 (halfValid || halveActive))
    else $error("stage order broken");
  a_negative_bias_rounding_round: assert property (@(posedge clk) disable iff (!rstn)
    iirValid && floorRound && iirData[W-1] && !satLo && !satHi
    |=> sampleOut == 16'(($past(iirData) >>> FRAC_BITS) + 1))
    else $error("negative_bias_rounding rounding wrong");
  a_chain_idle: assert property (@(posedge clk) disable iff (!rstn)
    !chainOn ##1 !chainOn |-> !sincValid && !dcfValid && !halfValid)
    else $error("decimation ran in an unsupported mode");
  a_ratio_bypass: assert property (@(posedge clk) disable iff (!rstn)
    sinc16 |-> !halveActive)
    else $error("halving stage active at 16x");
  a_halve_bypass: assert property (@(posedge clk) disable iff (!rstn)
    dcfValid && !halveActive && chainOn ##1 chainOn |-> halfValid && halfData == $past(dcfData))
    else $error("bypassed halving stage did not pass sample");
  a_droop_bypass: assert property (@(posedge clk) disable iff (!rstn)
    sincValid && droopBypass && chainOn ##1 chainOn |-> dcfData == $past(stage0))
    else $error("droop bypass did not pass sample");
  a_out_pulse: assert property (@(posedge clk) disable iff (!rstn)
    sampleValid |=> !sampleValid)
    else $error("output strobe longer than one cycle");

  c_halved_sample: cover property (@(posedge clk) disable iff (!rstn)
    sampleValid && halveActive);
  c_sinc16_sample: cover property (@(posedge clk) disable iff (!rstn)
    sampleValid && sinc16);
  c_iir1_negative_bias_rounding: cover property (@(posedge clk) disable iff (!rstn)
    sampleValid && iir1Active && floorRound && sampleOut[15]);

endmodule

//--- tb/acd_mod_model.sv
`timescale 1ns/1ps
// ------------------------------------------------
// Modulator stand-in: one bit per strobe
// ------------------------------------------------
module acd_mod_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Control from the bench
  input wire logic run,
  input wire logic level,
  input wire logic [3:0] gap,
  // Bit stream towards the chain
  output logic modValid,
  output logic modBit
);
  logic [3:0] cnt;

  // Strobe every gap+1 cycles; between strobes the bit toggles so no stale value looks valid
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt <= 4'h0;
      modValid <= 1'b0;
      modBit <= 1'b0;
    end else if (run && cnt >= gap) begin
      cnt <= 4'h0;
      modValid <= 1'b1;
      modBit <= level;
    end else begin
      cnt <= cnt + 4'h1;
      modValid <= 1'b0;
      modBit <= ~modBit;
    end
  end
endmodule

//--- tb/test_acd_filter_chain.sv
`timescale 1ns/1ps
module test_acd_filter_chain import acd_pkg::*;;
  logic clk = 0, rstn = 0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, modValid, modBit, sampleValid, modRun = 0, modLevel = 1;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf, modGap = 4'h0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic signed [15:0] sampleOut;
  logic [3:0] modes [3] = '{MODE_HP, MODE_RBW, MODE_LP};
  integer seed = 32'hfc7c5c27;
  int miscompares = 0, comparisons = 0;

  // ------------------------------------------------
  // Clock, design and modulator
  // ------------------------------------------------
  always #4 clk = ~clk;
  acd_filter_chain DUT (.clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .modValid, .modBit, .sampleValid, .sampleOut);
  acd_mod_model modulator (.clk, .rstn, .run(modRun), .level(modLevel), .gap(modGap),
    .modValid, .modBit);

  // ------------------------------------------------
  // Reporting
  // ------------------------------------------------
  task automatic final_report();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // A bound that runs out ends the run at once
  task automatic hang();
    miscompares++;
    $display("MISMATCH %0t wait bound ran out", $time);
    final_report();
  endtask

  // ------------------------------------------------
  // AXI4-Lite master: hold each channel until its own ready
  // ------------------------------------------------
  task automatic axw(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw, w;
    int n;
    aw = 0;
    w = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    for (n = 0; !(aw && w); n++) begin
      if (n > 50) hang();
      @(posedge clk);
      if (!aw && s_axi_awready === 1'b1) begin
        aw = 1;
        s_axi_awvalid <= 0;
      end
      if (!w && s_axi_wready === 1'b1) begin
        w = 1;
        s_axi_wvalid <= 0;
      end
    end
    s_axi_bready <= 1;
    for (n = 0; n == 0 || s_axi_bvalid !== 1'b1; n++) begin
      if (n > 50) hang();
      @(posedge clk);
    end
    r = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task automatic axr(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    for (n = 0; n == 0 || s_axi_arready !== 1'b1; n++) begin
      if (n > 50) hang();
      @(posedge clk);
    end
    s_axi_arvalid <= 0;
    s_axi_rready <= 1;
    for (n = 0; n == 0 || s_axi_rvalid !== 1'b1; n++) begin
      if (n > 50) hang();
      @(posedge clk);
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  task automatic wrc(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    axw(a, d, r);
    chk({30'h0, r}, {30'h0, er}, "bresp");
  endtask
  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] m, input logic [31:0] e,
                     input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    axr(a, d, r);
    chk(d & m, e, "rdata");
    chk({30'h0, r}, {30'h0, er}, "rresp");
  endtask

  // ------------------------------------------------
  // Stream: count modulator bits between output strobes
  // ------------------------------------------------
  task automatic meas(input int skip, output int cnt);
    int n, p;
    logic prev;
    p = 0;
    cnt = 0;
    prev = 0;
    for (n = 0; p <= skip; n++) begin
      if (n > 9000) hang();
      @(posedge clk);
      if (p == skip && modValid === 1'b1) cnt++;
      if (prev && sampleValid === 1'b1) chk(1, 0, "strobe wider than a cycle");
      prev = (sampleValid === 1'b1);
      if (sampleValid === 1'b1) p++;
    end
  endtask

  // Expected bits per output sample from the decimation settings
  function automatic int ratio(input logic [7:0] t);
    return t[TRIG_SINC16_BIT] ? 16 : (t[TRIG_HALVE_BYP_BIT] ? 32 : 64);
  endfunction
  // Expected full-scale sample; negative_bias_rounding rounding lifts the negative end by one
  function automatic logic [31:0] fullScale(input logic up, input logic flr);
    return up ? 32'h7fff : (flr ? 32'h8001 : 32'h8000);
  endfunction

  // ------------------------------------------------
  // Main sequence
  // ------------------------------------------------
  initial begin
    logic [7:0] t, f;
    logic [3:0] m;
    logic fl;
    int c, i;
    repeat (12) @(posedge clk);
    rstn <= 1;
    @(posedge clk);
    rdc(TRIG_ADDR, '1, 0, RESP_OKAY);
    rdc(FILT_ADDR, '1, 0, RESP_OKAY);
    rdc(12'h3fc, '1, 0, RESP_SLVERR);
    wrc(12'h3fc, 32'hff, RESP_SLVERR);
    wrc(STAT_ADDR, 32'hff, RESP_SLVERR);
    $display("test reset_and_map done");
    // Idle and SAR-type modes must not run the chain even with the IIR asked for
    modRun <= 1;
    wrc(FILT_ADDR, 32'h40, RESP_OKAY);
    wrc(TRIG_ADDR, 32'h20, RESP_OKAY);
    for (i = 0; i < 4; i++) begin
      wrc(CTRL_ADDR, i, RESP_OKAY);
      c = 0;
      repeat (400) begin
        @(posedge clk);
        if (sampleValid === 1'b1) c++;
      end
      chk(c, 0, "samples while idle");
      rdc(STAT_ADDR, 32'h9, 0, RESP_OKAY);
    end
    $display("test idle_modes done");
    // Random configurations with fixed corners first
    for (i = 0; i < 8; i++) begin
      t = $random(seed);
      f = $random(seed);
      fl = 1'($random(seed));
      m = modes[$unsigned($random(seed)) % 3];
      if (i == 0) t = 8'h00;
      if (i == 1) t = 8'hc0;
      if (i == 2) t = 8'h40;
      if (i == 3) t[5] = 1'b1;
      if (i < 3) f = 8'h00;
      if (t[5]) f[6:4] = 3'b100;
      if (t[6]) f[7] = 1'b1;
      modLevel <= 1'($random(seed));
      modGap <= 4'($unsigned($random(seed)) % 4);
      wrc(CTRL_ADDR, 0, RESP_OKAY);
      wrc(FILT_ADDR, {24'h0, f}, RESP_OKAY);
      wrc(TRIG_ADDR, {24'h0, t}, RESP_OKAY);
      wrc(CTRL_ADDR, {27'h0, fl, m}, RESP_OKAY);
      // Same value again with the chain running, so the enable lands in a run mode
      wrc(TRIG_ADDR, {24'h0, t}, RESP_OKAY);
      rdc(TRIG_ADDR, '1, {24'h0, t}, RESP_OKAY);
      rdc(FILT_ADDR, '1, {24'h0, f}, RESP_OKAY);
      rdc(CTRL_ADDR, '1, {27'h0, fl, m}, RESP_OKAY);
      rdc(STAT_ADDR, 32'hf, {28'h0, t[5], ~t[7] & ~t[6], t[6], 1'b1}, RESP_OKAY);
      meas(5, c);
      chk(c, ratio(t), "bits per sample");
      if (!t[5] && !t[6]) chk({16'h0, sampleOut}, fullScale(modLevel, fl), "level");
      // Freeze the stream so the reported sample cannot move under the read
      modRun <= 0;
      repeat (10) @(posedge clk);
      rdc(STAT_ADDR, 32'hffff0000, {sampleOut, 16'h0}, RESP_OKAY);
      modRun <= 1;
      $display("test config %0d done", i);
    end
    final_report();
  end
endmodule
